// ==== dv/tmrwv_asserts.sv ====
`timescale 1ns/10ps
module tmrwv_asserts (
	input wire ref_clk,
	input wire rst_b,
	input wire [7:0] addr,
	input wire [31:0] wdata,
	input wire wr,
	input wire rd,
	input wire [31:0] rdata,
	input wire [2:0] chan_io_b_oe,
	input wire [2:0] chan_irq
);
	logic [31:0] cmr_reg;
	logic [5:0] bmr_reg;
	logic [15:0] mva_reg;
	logic [7:0] imr_reg;
	logic [2:0] idle_reg;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_b);
	// shadows of channel 0 and block registers
	always @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			cmr_reg <= 0;
			bmr_reg <= 0;
			mva_reg <= 0;
			imr_reg <= 0;
			idle_reg <= 0;
		end else begin
			if (wr && addr == 8'h04) cmr_reg <= wdata;
			if (wr && addr == 8'hc4) bmr_reg <= wdata[5:0];
			if (wr && addr == 8'h14 && cmr_reg[15]) mva_reg <= wdata[15:0];
			if (wr && addr == 8'h24) imr_reg <= imr_reg | wdata[7:0];
			if (wr && addr == 8'h28) imr_reg <= imr_reg & ~wdata[7:0];
			idle_reg <= (imr_reg != 0) ? 3'h0 : ((idle_reg == 3'h7) ? 3'h7 : idle_reg + 3'h1);
		end
	end
	AST_RDATA_IDLE: assert property (!$past(rd) |-> rdata == 0)
		else $error("read data not zero outside read");
	AST_UNMAPPED: assert property (rd && addr < 8'hc0 && (addr[5:0] == 6'h08
		|| addr[5:0] == 6'h0c || addr[5:0] > 6'h2c) |=> rdata == 0)
		else $error("reserved channel offset read not zero");
	AST_HIGH_UNMAPPED: assert property (rd && addr > 8'hc4 |=> rdata == 0)
		else $error("reserved block offset read not zero");
	AST_CMR_READ: assert property (rd && addr == 8'h04 |=>
		{rdata[31:14], rdata[12:6]} == {cmr_reg[31:14], cmr_reg[12:6]})
		else $error("mode readback wrong");
	AST_BMR_READ: assert property (rd && addr == 8'hc4 |=> rdata[5:0] == bmr_reg)
		else $error("block mode readback wrong");
	AST_MVA_GUARD: assert property (rd && addr == 8'h14 |=> rdata[15:0] == mva_reg)
		else $error("match a write not guarded by mode");
	AST_IMR_READ: assert property (rd && addr == 8'h2c |=> rdata[7:0] == imr_reg)
		else $error("mask readback wrong");
	AST_IRQ_MASKED: assert property (idle_reg >= 3'h4 |-> !chan_irq[0])
		else $error("irq with empty mask");
	AST_OE_STEADY: assert property ($changed(chan_io_b_oe) |->
		$past(wr) || $past(wr, 2) || $past(wr, 3))
		else $error("io b enable moved without mode write");
endmodule
bind tmrwv_top tmrwv_asserts tmrwv_asserts_inst (.ref_clk(ref_clk), .rst_b(rst_b),
	.addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
	.chan_io_b_oe(chan_io_b_oe), .chan_irq(chan_irq));

// ==== dv/tmrwv_partner.sv ====
`timescale 1ns/10ps
module tmrwv_partner (
	input wire [2:0] pin_lvl,
	input wire [2:0] iob_lvl,
	input wire [2:0] io_b_out,
	input wire [2:0] io_b_oe,
	output wire [2:0] clk_pin,
	output wire [2:0] chan_io_b_in
);
	// outside source moves off the clock edge
	assign #3 clk_pin = pin_lvl;
	// wire level: block wins where it drives
	assign chan_io_b_in = (io_b_oe & io_b_out) | (~io_b_oe & iob_lvl);
endmodule

// ==== dv/tmrwv_top_tb.sv ====
`timescale 1ns/10ps
module tmrwv_top_tb;
	logic ref_clk, rst_b, wr, rd;
	logic [7:0] addr;
	logic [31:0] wdata, q;
	logic [2:0] pin_lvl, iob_lvl;
	wire [2:0] clk_pin, chan_io_b_in, chan_io_a, chan_io_b_out, chan_io_b_oe, chan_irq;
	wire [31:0] rdata;
	int errors, num_checks;
	logic [71:0] rows [0:6];
	logic [7:0] zero_addrs [0:6];
	logic [1:0] codes [0:5];
	logic exp_a [0:5];
	tmrwv_top tmrwv_top_inst (.ref_clk(ref_clk), .rst_b(rst_b), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd), .rdata(rdata), .clk_pin(clk_pin), .chan_io_b_in(chan_io_b_in),
		.chan_io_a(chan_io_a), .chan_io_b_out(chan_io_b_out), .chan_io_b_oe(chan_io_b_oe),
		.chan_irq(chan_irq));
	tmrwv_partner tmrwv_partner_inst (.pin_lvl(pin_lvl), .iob_lvl(iob_lvl),
		.io_b_out(chan_io_b_out), .io_b_oe(chan_io_b_oe), .clk_pin(clk_pin),
		.chan_io_b_in(chan_io_b_in));
	initial begin
		ref_clk = 0;
		forever #5 ref_clk = ~ref_clk;
	end
	task chk(input [31:0] s, input [31:0] e);
		num_checks++;
		if (s !== e) begin
			errors++;
			$display("Error %0t: got %h want %h", $time, s, e);
		end
	endtask
	task w(input [7:0] a, input [31:0] d);
		@(posedge ref_clk);
		addr <= a;
		wdata <= d;
		wr <= 1;
		@(posedge ref_clk);
		wr <= 0;
	endtask
	task r(input [7:0] a);
		@(posedge ref_clk);
		addr <= a;
		rd <= 1;
		@(posedge ref_clk);
		rd <= 0;
		#1 q = rdata;
	endtask
	task rdc(input [7:0] a, input [31:0] e);
		r(a);
		chk(q, e);
	endtask
	task lv(input v);
		@(posedge ref_clk);
		pin_lvl[0] <= v;
		repeat (8) @(posedge ref_clk);
	endtask
	task report_and_stop;
		if (errors == 0 && num_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge ref_clk);
		errors++;
		report_and_stop;
	end
	initial begin
		rst_b = 0;
		wr = 0;
		rd = 0;
		addr = 0;
		wdata = 0;
		q = 0;
		pin_lvl = 0;
		iob_lvl = 3'h5;
		zero_addrs = '{8'h04, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h2c, 8'hc4};
		rows = '{{8'h04, 32'h0000_8000, 32'h0000_8000}, {8'h14, 32'h0000_1234, 32'h0000_1234},
			{8'h18, 32'h0000_5678, 32'h0000_5678}, {8'h1c, 32'h0000_0040, 32'h0000_0040},
			{8'h44, 32'h0000_0000, 32'h0000_0000}, {8'h84, 32'h0000_8400, 32'h0000_8400},
			{8'hc4, 32'h0000_0039, 32'h0000_0039}};
		codes = '{2'h1, 2'h1, 2'h3, 2'h3, 2'h2, 2'h0};
		exp_a = '{1, 1, 0, 1, 0, 0};
		repeat (20) @(posedge ref_clk);
		rst_b <= 1;
		for (int i = 0; i < 7; i++) rdc(zero_addrs[i], 0);
		for (int i = 0; i < 7; i++) begin
			w(rows[i][71:64], rows[i][63:32]);
			rdc(rows[i][71:64], rows[i][31:0]);
		end
		w(8'h24, 32'h0000_009d);
		rdc(8'h2c, 32'h0000_009d);
		w(8'h28, 32'h0000_001d);
		rdc(8'h2c, 32'h0000_0080);
		rdc(8'h08, 0);
		rdc(8'hd0, 0);
		w(8'h54, 32'h0000_00aa);
		rdc(8'h54, 0);
		// line 0 event, rising edge, trigger on, io b set on event
		w(8'h04, 32'h1000_9500);
		w(8'h00, 32'h0000_0001);
		r(8'h20);
		lv(1);
		chk(chan_io_b_oe[0], 1);
		r(8'h20);
		chk(q[7], 0);
		lv(0);
		w(8'hc4, 0);
		r(8'h20);
		lv(1);
		chk(chan_irq[0], 1);
		r(8'h20);
		chk(q[7], 1);
		chk(chan_io_b_out[0], 1);
		r(8'h10);
		chk(q[15:0] != 0, 1);
		lv(0);
		r(8'h20);
		chk(q[7], 0);
		w(8'h04, 32'h0000_8000);
		repeat (4) @(posedge ref_clk);
		chk(chan_io_b_oe[0], 0);
		for (int i = 0; i < 6; i++) begin
			w(8'h04, 32'h0000_8000 | (codes[i] << 22));
			w(8'h00, 32'h0000_0004);
			repeat (4) @(posedge ref_clk);
			chk(chan_io_a[0], exp_a[i]);
		end
		w(8'h00, 32'h0000_0003);
		r(8'h20);
		chk(q[16], 0);
		w(8'h00, 32'h0000_0001);
		r(8'h20);
		chk(q[16], 1);
		w(8'h00, 0);
		r(8'h20);
		chk(q[16], 1);
		w(8'h00, 32'h0000_0005);
		repeat (40) @(posedge ref_clk);
		w(8'hc0, 0);
		r(8'h10);
		chk(q[15:0] > 16'h0020, 1);
		w(8'hc0, 32'h0000_0001);
		r(8'h10);
		chk(q[15:0] < 16'h0010, 1);
		repeat (80) @(posedge ref_clk);
		r(8'h20);
		chk(q[4], 1);
		r(8'h20);
		chk(q[4], 0);
		// run the counter across both match values and past the top
		w(8'h10, 32'h0000_1230);
		repeat (10) @(posedge ref_clk);
		w(8'h10, 32'h0000_5670);
		repeat (10) @(posedge ref_clk);
		w(8'h10, 32'h0000_fff0);
		repeat (24) @(posedge ref_clk);
		r(8'h20);
		chk(q[2], 1);
		chk(q[3], 1);
		chk(q[0], 1);
		w(8'h28, 32'h0000_0080);
		report_and_stop;
	end
endmodule

// ==== verilog/tmrwv_channel.v ====
// The plain strobed port was left to the implementer.
`timescale 1ns/10ps
`include "tmrwv_consts.vh"
module tmrwv_channel (
	input wire ref_clk,
	input wire rst_b,
	input wire [5:0] off,
	input wire [31:0] wdata,
	input wire wr,
	input wire rd,
	input wire sync_pulse,
	input wire [2:0] xc_lines,
	input wire io_b_in,
	output reg [31:0] rdata,
	output reg io_a_reg,
	output reg io_b_reg,
	output reg io_b_oe_reg,
	output reg irq_reg
);
	reg [31:0] mode_reg;
	reg [15:0] cnt_reg;
	reg [15:0] mva_reg;
	reg [15:0] mvb_reg;
	reg [15:0] pmv_reg;
	reg [7:0] flags_reg;
	reg [7:0] mask_reg;
	reg clk_en_reg;
	reg run_reg;
	reg evt_prev_reg;
	reg [15:0] cnt_prev_reg;
	wire wave = mode_reg[`TMRWV_MODE_WAVE];
	wire [1:0] esel = mode_reg[`TMRWV_MODE_ESEL+1:`TMRWV_MODE_ESEL];
	wire [1:0] eedg = mode_reg[`TMRWV_MODE_EEDG+1:`TMRWV_MODE_EEDG];
	wire w_ccr = wr && off == `TMRWV_OFF_CCR;
	wire on_cmd = w_ccr && wdata[`TMRWV_CMD_CLKON];
	wire off_cmd = w_ccr && wdata[`TMRWV_CMD_CLKOFF];
	wire sw_cmd = (w_ccr && wdata[`TMRWV_CMD_SOFT]) || sync_pulse;
	wire evt_sig = (esel == 2'b00) ? io_b_in : xc_lines[esel - 2'b01];
	wire rise = evt_sig && !evt_prev_reg;
	wire fall = !evt_sig && evt_prev_reg;
	wire evt = wave && ((eedg == `TMRWV_EDG_RISE && rise) ||
		(eedg == `TMRWV_EDG_FALL && fall) || (eedg == `TMRWV_EDG_BOTH && (rise || fall)));
	wire etrg = evt && mode_reg[`TMRWV_MODE_ETRG];
	// new counter value this cycle
	wire cnt_new = cnt_reg != cnt_prev_reg;
	wire ma = wave && cnt_new && cnt_reg == mva_reg;
	wire mb = wave && cnt_new && cnt_reg == mvb_reg;
	wire pm = cnt_new && cnt_reg == pmv_reg;
	wire ptrg = pm && mode_reg[`TMRWV_MODE_PTRG];
	wire trig = sw_cmd || etrg || ptrg;
	wire counting = clk_en_reg && run_reg;
	wire ovf = counting && !trig && cnt_reg == 16'hffff;
	wire [7:0] ev_bits = ({7'd0, ovf} << `TMRWV_SR_OVF) | ({7'd0, ma} << `TMRWV_SR_MA) |
		({7'd0, mb} << `TMRWV_SR_MB) | ({7'd0, pm} << `TMRWV_SR_PM) |
		({7'd0, etrg} << `TMRWV_SR_ETRG);
	wire rd_sr = rd && off == `TMRWV_OFF_SR;

	function out_next;
		input cur;
		input s, e, p, m;
		input [1:0] as, ae, ap, am;
		reg [1:0] act;
		begin
			act = s ? as : (e ? ae : (p ? ap : (m ? am : 2'b00)));
			if (!(s | e | p | m) || act == 2'b00)
				act = 2'b00;
			case (act)
			`TMRWV_ACT_SET: out_next = 1'b1;
			`TMRWV_ACT_CLR: out_next = 1'b0;
			`TMRWV_ACT_TGL: out_next = !cur;
			default: out_next = cur;
			endcase
		end
	endfunction

	always @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			mode_reg <= `TMRWV_MODE_RST;
			cnt_reg <= 16'h0000;
			cnt_prev_reg <= 16'h0000;
			mva_reg <= 16'h0000;
			mvb_reg <= 16'h0000;
			pmv_reg <= 16'h0000;
			flags_reg <= 8'h00;
			mask_reg <= 8'h00;
			clk_en_reg <= 1'b0;
			run_reg <= 1'b0;
			evt_prev_reg <= 1'b0;
			io_a_reg <= 1'b0;
			io_b_reg <= 1'b0;
			io_b_oe_reg <= 1'b0;
			irq_reg <= 1'b0;
			rdata <= 32'h0000_0000;
		end else begin
			evt_prev_reg <= evt_sig;
			cnt_prev_reg <= cnt_reg;
			if (wr && off == `TMRWV_OFF_CMR)
				mode_reg <= wdata;
			if (wr && off == `TMRWV_OFF_PMV)
				pmv_reg <= wdata[15:0];
			// match values locked in capture mode
			if (wr && off == `TMRWV_OFF_MVA && wave)
				mva_reg <= wdata[15:0];
			if (wr && off == `TMRWV_OFF_MVB && wave)
				mvb_reg <= wdata[15:0];
			if (off_cmd)
				clk_en_reg <= 1'b0;
			else if (on_cmd)
				clk_en_reg <= 1'b1;
			else if (pm && wave && mode_reg[`TMRWV_MODE_PDIS])
				clk_en_reg <= 1'b0;
			if (trig)
				run_reg <= 1'b1;
			else if (pm && wave && mode_reg[`TMRWV_MODE_PSTOP])
				run_reg <= 1'b0;
			if (wr && off == `TMRWV_OFF_CV)
				cnt_reg <= wdata[15:0];
			else if (trig)
				cnt_reg <= 16'h0000;
			else if (counting)
				cnt_reg <= cnt_reg + 16'h0001;
			flags_reg <= (rd_sr ? 8'h00 : flags_reg) | ev_bits;
			if (wr && off == `TMRWV_OFF_IER)
				mask_reg <= mask_reg | wdata[7:0];
			else if (wr && off == `TMRWV_OFF_IDR)
				mask_reg <= mask_reg & ~wdata[7:0];
			irq_reg <= |(flags_reg & mask_reg);
			io_a_reg <= wave ? out_next(io_a_reg, sw_cmd, evt, pm, ma,
				mode_reg[`TMRWV_MODE_ASW+1:`TMRWV_MODE_ASW],
				mode_reg[`TMRWV_MODE_AEEV+1:`TMRWV_MODE_AEEV],
				mode_reg[`TMRWV_MODE_A_PERIOD+1:`TMRWV_MODE_A_PERIOD],
				mode_reg[`TMRWV_MODE_A_MATCH+1:`TMRWV_MODE_A_MATCH]) : io_a_reg;
			io_b_reg <= wave ? out_next(io_b_reg, sw_cmd, evt, pm, mb,
				mode_reg[`TMRWV_MODE_BSW+1:`TMRWV_MODE_BSW],
				mode_reg[`TMRWV_MODE_BEEV+1:`TMRWV_MODE_BEEV],
				mode_reg[`TMRWV_MODE_B_PERIOD+1:`TMRWV_MODE_B_PERIOD],
				mode_reg[`TMRWV_MODE_B_MATCH+1:`TMRWV_MODE_B_MATCH]) : io_b_reg;
			// io b drives only as output
			io_b_oe_reg <= wave && esel != 2'b00;
			rdata <= 32'h0000_0000;
			if (rd) begin
				case (off)
				`TMRWV_OFF_CMR: rdata <= mode_reg;
				`TMRWV_OFF_CV: rdata <= {16'h0000, cnt_reg};
				`TMRWV_OFF_MVA: rdata <= {16'h0000, mva_reg};
				`TMRWV_OFF_MVB: rdata <= {16'h0000, mvb_reg};
				`TMRWV_OFF_PMV: rdata <= {16'h0000, pmv_reg};
				`TMRWV_OFF_SR: rdata <= {15'h0000, clk_en_reg, 8'h00, flags_reg};
				`TMRWV_OFF_IMR: rdata <= {24'h00_0000, mask_reg};
				default: rdata <= 32'h0000_0000;
				endcase
			end
		end
	end
endmodule

// ==== verilog/tmrwv_consts.vh ====
// What this block does
// - event from ext clock line or io b
// - edge field picks rising, falling, both, none
// - select zero makes io b input only
// - event triggers counter only when enabled
// - sync, soft and period triggers stay usable
// - io b driven only when not event input
// - per-output set/clear/toggle action fields
// - priority soft, event, period, match
// - sticky match a and b flags
// - sticky period flag until status read
// - sticky overflow flag past ffff
// - sticky external trigger flag
// - channels at 00/40/80, block at c0/c4
// - match a/b writable only in waveform mode
// - block control bit0 syncs all channels
// - line0 routing: pin0, none, ch1 a, ch2 a
// - line1 routing: pin1, none, ch0 a, ch2 a
// - line2 routing: pin2, none, ch0 a, ch1 a
// - control bits: clock on, off, trigger
// - event select codes io b, lines 0-2
// - edge codes none, rise, fall, both
// - soft trigger resets counter, sets run, leaves clock enable as is
// - clock off wins over clock on
`ifndef TMRWV_CONSTS_VH
`define TMRWV_CONSTS_VH
`define TMRWV_CH_STRIDE 8'h40
`define TMRWV_OFF_CCR 6'h00
`define TMRWV_OFF_CMR 6'h04
`define TMRWV_OFF_CV 6'h10
`define TMRWV_OFF_MVA 6'h14
`define TMRWV_OFF_MVB 6'h18
`define TMRWV_OFF_PMV 6'h1c
`define TMRWV_OFF_SR 6'h20
`define TMRWV_OFF_IER 6'h24
`define TMRWV_OFF_IDR 6'h28
`define TMRWV_OFF_IMR 6'h2c
`define TMRWV_OFF_BCR 8'hc0
`define TMRWV_OFF_BMR 8'hc4
`define TMRWV_CMD_CLKON 0
`define TMRWV_CMD_CLKOFF 1
`define TMRWV_CMD_SOFT 2
`define TMRWV_BCR_SYNC 0
`define TMRWV_MODE_WAVE 15
`define TMRWV_MODE_PTRG 14
`define TMRWV_MODE_ETRG 12
`define TMRWV_MODE_ESEL 10
`define TMRWV_MODE_EEDG 8
`define TMRWV_MODE_PDIS 7
`define TMRWV_MODE_PSTOP 6
`define TMRWV_MODE_A_MATCH 16
`define TMRWV_MODE_A_PERIOD 18
`define TMRWV_MODE_AEEV 20
`define TMRWV_MODE_ASW 22
`define TMRWV_MODE_B_MATCH 24
`define TMRWV_MODE_B_PERIOD 26
`define TMRWV_MODE_BEEV 28
`define TMRWV_MODE_BSW 30
`define TMRWV_SR_OVF 0
`define TMRWV_SR_MA 2
`define TMRWV_SR_MB 3
`define TMRWV_SR_PM 4
`define TMRWV_SR_ETRG 7
`define TMRWV_SR_CLKON 16
`define TMRWV_ACT_SET 2'b01
`define TMRWV_ACT_CLR 2'b10
`define TMRWV_ACT_TGL 2'b11
`define TMRWV_EDG_RISE 2'b01
`define TMRWV_EDG_FALL 2'b10
`define TMRWV_EDG_BOTH 2'b11
`define TMRWV_ROUTE_PIN 2'b00
`define TMRWV_ROUTE_NONE 2'b01
`define TMRWV_ROUTE_FIRST 2'b10
`define TMRWV_MODE_RST 32'h0000_0000
`endif

// ==== verilog/tmrwv_sync2.v ====
`timescale 1ns/10ps
module tmrwv_sync2 #(
	parameter W = 1
) (
	input wire ref_clk,
	input wire rst_b,
	input wire [W-1:0] d,
	output reg [W-1:0] q
);
	reg [W-1:0] meta_reg;
	always @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			meta_reg <= {W{1'b0}};
			q <= {W{1'b0}};
		end else begin
			meta_reg <= d;
			q <= meta_reg;
		end
	end
endmodule

// ==== verilog/tmrwv_top.v ====
`timescale 1ns/10ps
`include "tmrwv_consts.vh"
module tmrwv_top (
	input wire ref_clk,
	input wire rst_b,
	input wire [7:0] addr,
	input wire [31:0] wdata,
	input wire wr,
	input wire rd,
	output reg [31:0] rdata,
	input wire [2:0] clk_pin,
	input wire [2:0] chan_io_b_in,
	output reg [2:0] chan_io_a,
	output reg [2:0] chan_io_b_out,
	output reg [2:0] chan_io_b_oe,
	output reg [2:0] chan_irq
);
	wire [2:0] pin_s;
	wire [2:0] iob_s;
	reg [5:0] bmr_reg;
	reg sync_reg;
	reg blk_rd_reg;
	reg [1:0] rsel_reg;
	reg [2:0] ext_clk_line;
	wire [95:0] ch_rdata;
	wire [2:0] io_a;
	wire [2:0] io_b;
	wire [2:0] io_oe;
	wire [2:0] irq;
	wire [1:0] sel = addr[7:6];

	tmrwv_sync2 #(.W(6)) u_sync (
		.ref_clk(ref_clk),
		.rst_b(rst_b),
		.d({chan_io_b_in, clk_pin}),
		.q({iob_s, pin_s})
	);

	always @* begin
		case (bmr_reg[1:0])
		`TMRWV_ROUTE_PIN: ext_clk_line[0] = pin_s[0];
		`TMRWV_ROUTE_FIRST: ext_clk_line[0] = io_a[1];
		2'b11: ext_clk_line[0] = io_a[2];
		default: ext_clk_line[0] = 1'b0;
		endcase
		case (bmr_reg[3:2])
		`TMRWV_ROUTE_PIN: ext_clk_line[1] = pin_s[1];
		`TMRWV_ROUTE_FIRST: ext_clk_line[1] = io_a[0];
		2'b11: ext_clk_line[1] = io_a[2];
		default: ext_clk_line[1] = 1'b0;
		endcase
		case (bmr_reg[5:4])
		`TMRWV_ROUTE_PIN: ext_clk_line[2] = pin_s[2];
		`TMRWV_ROUTE_FIRST: ext_clk_line[2] = io_a[0];
		2'b11: ext_clk_line[2] = io_a[1];
		default: ext_clk_line[2] = 1'b0;
		endcase
	end

	genvar i;
	generate
		for (i = 0; i < 3; i = i + 1) begin : g_ch
			tmrwv_channel u_ch (
				.ref_clk(ref_clk),
				.rst_b(rst_b),
				.off(addr[5:0]),
				.wdata(wdata),
				.wr(wr && sel == i),
				.rd(rd && sel == i),
				.sync_pulse(sync_reg),
				.xc_lines(ext_clk_line),
				.io_b_in(iob_s[i]),
				.rdata(ch_rdata[32*i+31:32*i]),
				.io_a_reg(io_a[i]),
				.io_b_reg(io_b[i]),
				.io_b_oe_reg(io_oe[i]),
				.irq_reg(irq[i])
			);
		end
	endgenerate

	always @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			bmr_reg <= 6'h00;
			sync_reg <= 1'b0;
			blk_rd_reg <= 1'b0;
			rsel_reg <= 2'b00;
			chan_io_a <= 3'b000;
			chan_io_b_out <= 3'b000;
			chan_io_b_oe <= 3'b000;
			chan_irq <= 3'b000;
		end else begin
			if (wr && addr == `TMRWV_OFF_BMR)
				bmr_reg <= wdata[5:0];
			sync_reg <= wr && addr == `TMRWV_OFF_BCR && wdata[`TMRWV_BCR_SYNC];
			blk_rd_reg <= rd && addr == `TMRWV_OFF_BMR;
			rsel_reg <= sel;
			chan_io_a <= io_a;
			chan_io_b_out <= io_b;
			chan_io_b_oe <= io_oe;
			chan_irq <= irq;
		end
	end

	always @* begin
		if (blk_rd_reg)
			rdata = {26'h000_0000, bmr_reg};
		else if (rsel_reg == 2'b11)
			rdata = 32'h0000_0000;
		else
			rdata = ch_rdata[32*rsel_reg +: 32];
	end
endmodule
